// ---- verilog/dra_rx_alarm_irq.sv ----
// ds3 receive alarm interrupt block with apb register slave
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
module dra_rx_alarm_irq #(
   parameter int unsigned AIS_FRAMES  = dra_pkg::AIS_FRAMES,
   parameter int unsigned FBIT_WINDOW = dra_pkg::FBIT_WINDOW
) (
   input  wire logic                         i_clk,
   input  wire logic                         i_rst_n,
   input  wire logic                         i_psel,
   input  wire logic                         i_penable,
   input  wire logic                         i_pwrite,
   input  wire logic [dra_pkg::ADDR_W-1:0]   i_paddr,
   input  wire logic [31:0]                  i_pwdata,
   output logic      [31:0]                  o_prdata,
   output logic                              o_pready,
   output logic                              o_pslverr,
   input  wire dra_pkg::dra_rx_t             i_rx,
   output dra_pkg::dra_cfg_t                 o_cfg,
   output logic                              o_frame_loss_state,
   output logic                              o_alarm_signal_state,
   output logic                              o_ferf_send,
   output logic                              o_irq_n
);
   if (AIS_FRAMES < 2 || FBIT_WINDOW < dra_pkg::OOF_THR_HIGH)
   begin : g_bad
      $error("dra_rx_alarm_irq: unsupported parameters");
   end

   localparam logic [dra_pkg::ADDR_W-1:0] A_CFG  =
      dra_pkg::ADDR_W'({dra_pkg::IDX_CFG_STATE, 2'b00});
   localparam logic [dra_pkg::ADDR_W-1:0] A_EN   =
      dra_pkg::ADDR_W'({dra_pkg::IDX_IRQ_EN, 2'b00});
   localparam logic [dra_pkg::ADDR_W-1:0] A_STAT =
      dra_pkg::ADDR_W'({dra_pkg::IDX_IRQ_STAT, 2'b00});

   typedef enum logic [3:0] {
      SEL_CFG  = 4'b0001,
      SEL_EN   = 4'b0010,
      SEL_STAT = 4'b0100,
      SEL_NONE = 4'b1000
   } dra_sel_t;

   function automatic dra_sel_t decode(input logic [dra_pkg::ADDR_W-1:0] a);
      dra_sel_t s;
      s = SEL_NONE;
      if (a == A_CFG)
         s = SEL_CFG;
      else if (a == A_EN)
         s = SEL_EN;
      else if (a == A_STAT)
         s = SEL_STAT;
      return s;
   endfunction

   dra_pkg::dra_cfg_t cfg_q;
   logic [7:0]        en_q;
   logic [7:0]        stat_q;
   logic [7:0]        stat_d;
   logic [7:0]        rd_clear_mask_q;
   logic [31:0]       prdata_q;
   logic              pslverr_q;
   logic [7:0]        state_now;
   logic [7:0]        state_q;
   logic [7:0]        change;
   logic [7:0]        pulse_src;
   logic [7:0]        level_src;
   logic [7:0]        event_v;
   logic [7:0]        cfg_rd;
   logic              oof;
   logic              ais;
   logic              setup;
   logic              access;
   dra_sel_t          sel_setup;
   dra_sel_t          sel_access;

   assign setup      = i_psel && !i_penable;
   assign access     = i_psel && i_penable;
   assign sel_setup  = decode(i_paddr);
   assign sel_access = decode(i_paddr);

   dra_oof_detect #(
      .WINDOW   (FBIT_WINDOW),
      .THR_LOW  (dra_pkg::OOF_THR_LOW),
      .THR_HIGH (dra_pkg::OOF_THR_HIGH)
   ) u_oof (
      .i_clk              (i_clk),
      .i_rst_n            (i_rst_n),
      .i_fbit_valid       (i_rx.fbit_valid),
      .i_fbit_err         (i_rx.fbit_err),
      .i_thr_high         (cfg_q.f_bit_sync_select),
      .i_inframe_entry    (i_rx.inframe_entry),
      .o_frame_loss_state (oof)
   );

   dra_ais_detect #(
      .FRAMES (AIS_FRAMES)
   ) u_ais (
      .i_clk                (i_clk),
      .i_rst_n              (i_rst_n),
      .i_frame_end          (i_rx.frame_end),
      .i_frame_ais          (i_rx.frame_ais),
      .o_alarm_signal_state (ais)
   );

   // live alarm levels in status bit order, unused positions zero
   always_comb
   begin
      state_now                   = 8'h00;
      state_now[dra_pkg::BIT_LOS]  = i_rx.signal_loss_state;
      state_now[dra_pkg::BIT_AIS]  = ais;
      state_now[dra_pkg::BIT_IDLE] = i_rx.idle_pattern_state;
      state_now[dra_pkg::BIT_OOF]  = oof;
   end

   // single-cycle event sources
   always_comb
   begin
      pulse_src                   = 8'h00;
      pulse_src[dra_pkg::BIT_CP]   = i_rx.cp_err;
      pulse_src[dra_pkg::BIT_FERF] = i_rx.ferf_change;
      pulse_src[dra_pkg::BIT_AIC]  = i_rx.aic_change;
      pulse_src[dra_pkg::BIT_PERR] = i_rx.p_err;
   end

   assign level_src = 8'h00
                    | (8'h01 << dra_pkg::BIT_LOS)
                    | (8'h01 << dra_pkg::BIT_AIS)
                    | (8'h01 << dra_pkg::BIT_IDLE)
                    | (8'h01 << dra_pkg::BIT_OOF);

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         state_q <= 8'h00;
      else
         state_q <= state_now;
   end

   // per-source event: edges of level sources, pulses for the rest
   for (genvar g = 0; g < 8; g++)
   begin : g_evt
      assign change[g]  = level_src[g] ? (state_now[g] ^ state_q[g]) : pulse_src[g];
      assign event_v[g] = change[g] && en_q[g];
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         en_q <= dra_pkg::RST_IRQ_EN;
      else if (access && i_pwrite && sel_access == SEL_EN)
         en_q <= i_pwdata[7:0];
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         cfg_q <= dra_pkg::dra_cfg_t'(dra_pkg::RST_CFG_SEL);
      else if (access && i_pwrite && sel_access == SEL_CFG)
         cfg_q <= dra_pkg::dra_cfg_t'(i_pwdata[2:0]);
   end

   always_comb
   begin
      stat_d = stat_q;
      if (access && !i_pwrite && sel_access == SEL_STAT)
         stat_d = stat_q & ~rd_clear_mask_q;
      stat_d = stat_d | event_v;
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         stat_q <= dra_pkg::RST_IRQ_STAT;
      else
         stat_q <= stat_d;
   end

   always_comb
   begin
      cfg_rd                    = {5'h00, cfg_q};
      cfg_rd[dra_pkg::CFG_AIS]  = ais;
      cfg_rd[dra_pkg::CFG_LOS]  = i_rx.signal_loss_state;
      cfg_rd[dra_pkg::CFG_IDLE] = i_rx.idle_pattern_state;
      cfg_rd[dra_pkg::CFG_OOF]  = oof;
      cfg_rd[dra_pkg::CFG_RSVD] = 1'b0;
   end

   // read data captured in the setup cycle
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         prdata_q <= 32'h0000_0000;
      else if (setup && !i_pwrite)
      begin
         unique case (sel_setup)
            SEL_CFG:  prdata_q <= {24'h00_0000, cfg_rd};
            SEL_EN:   prdata_q <= {24'h00_0000, en_q};
            SEL_STAT: prdata_q <= {24'h00_0000, stat_q};
            SEL_NONE: prdata_q <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         rd_clear_mask_q <= 8'h00;
      else if (setup)
         rd_clear_mask_q <= (sel_setup == SEL_STAT && !i_pwrite) ? stat_q : 8'h00;
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         pslverr_q <= 1'b0;
      else if (setup)
         pslverr_q <= (sel_setup == SEL_NONE);
   end

   assign o_prdata  = prdata_q;
   assign o_pready  = access;
   assign o_pslverr = access && pslverr_q;

   assign o_cfg                = cfg_q;
   assign o_frame_loss_state   = oof;
   assign o_alarm_signal_state = ais;
   // ferf upon oof, and upon ais
   assign o_ferf_send          = oof || ais;
   // irq from enabled status, held until read
   assign o_irq_n              = ~|(stat_q & en_q);

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_stat_read;
      access && !i_pwrite && sel_access == SEL_STAT;
   endsequence

   sequence s_read_setup;
      setup && !i_pwrite && sel_setup == SEL_STAT;
   endsequence

   property p_ais_event_sets;
      event_v[dra_pkg::BIT_AIS] |=> stat_q[dra_pkg::BIT_AIS] && !o_irq_n;
   endproperty
   a_ais_event_sets: assert property (p_ais_event_sets)
      else $error("ais event did not set status and irq");

   property p_oof_event_sets;
      $changed(oof) && en_q[dra_pkg::BIT_OOF] |=> stat_q[dra_pkg::BIT_OOF] && !o_irq_n;
   endproperty
   a_oof_event_sets: assert property (p_oof_event_sets)
      else $error("oof change did not set status bit 1");

   property p_no_set_disabled;
      !$past(event_v[dra_pkg::BIT_AIS]) && !$past(stat_q[dra_pkg::BIT_AIS])
         |-> !stat_q[dra_pkg::BIT_AIS];
   endproperty
   a_no_set_disabled: assert property (p_no_set_disabled)
      else $error("ais status set without an enabled event");

   property p_read_clears;
      s_read_setup ##1 (s_stat_read and !(|event_v))
         |=> stat_q == 8'h00 || $past(stat_q, 1) != $past(stat_q, 2);
   endproperty
   a_read_clears: assert property (p_read_clears)
      else $error("status not cleared by read");

   property p_read_keeps_event;
      s_stat_read and event_v[dra_pkg::BIT_AIS] |=> stat_q[dra_pkg::BIT_AIS];
   endproperty
   a_read_keeps_event: assert property (p_read_keeps_event)
      else $error("event lost in read cycle");

   property p_irq_level;
      (|(stat_q & en_q)) == !o_irq_n;
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("irq level does not match enabled status");

   property p_ferf;
      o_ferf_send == (o_frame_loss_state || o_alarm_signal_state);
   endproperty
   a_ferf: assert property (p_ferf)
      else $error("ferf send does not follow oof or ais");

   property p_cfg_live;
      s_read_setup or (setup && !i_pwrite && sel_setup == SEL_CFG)
         |=> sel_setup == SEL_STAT || sel_setup != SEL_CFG
         || (prdata_q[dra_pkg::CFG_OOF] == $past(oof) && prdata_q[dra_pkg::CFG_AIS] == $past(ais));
   endproperty
   a_cfg_live: assert property (p_cfg_live)
      else $error("live state readback mismatch");

   property p_en_write;
      access && i_pwrite && sel_access == SEL_EN |=> en_q == $past(i_pwdata[7:0]);
   endproperty
   a_en_write: assert property (p_en_write)
      else $error("enable register not written");

   property p_ais_both_edges;
      $changed(ais) && en_q[dra_pkg::BIT_AIS] |-> event_v[dra_pkg::BIT_AIS];
   endproperty
   a_ais_both_edges: assert property (p_ais_both_edges)
      else $error("ais edge did not raise an event");

   property p_oof_clear;
      i_rx.inframe_entry |=> !oof;
   endproperty
   a_oof_clear: assert property (p_oof_clear)
      else $error("oof not cleared on in-frame entry");

   property p_rsvd_zero;
      setup && !i_pwrite && sel_setup == SEL_CFG |=> prdata_q[dra_pkg::CFG_RSVD] == 1'b0;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero)
      else $error("reserved bit reads nonzero");

   property p_read_keeps_any;
      s_stat_read and (|event_v) |=> (stat_q & $past(event_v)) == $past(event_v);
   endproperty
   a_read_keeps_any: assert property (p_read_keeps_any)
      else $error("event lost in status read cycle");

   property p_ais_on_frame;
      !i_rx.frame_end |=> $stable(ais);
   endproperty
   a_ais_on_frame: assert property (p_ais_on_frame)
      else $error("ais state changed without a frame");

   property p_cfg_write;
      access && i_pwrite && sel_access == SEL_CFG |=> o_cfg == $past(i_pwdata[2:0]);
   endproperty
   a_cfg_write: assert property (p_cfg_write)
      else $error("config selects not written");
endmodule // dra_rx_alarm_irq

// ---- verilog/dra_pkg.sv ----
// constants and types for the ds3 receive alarm interrupt block
package dra_pkg;
   localparam int unsigned ADDR_W        = 8;
   localparam logic [7:0]  IDX_CFG_STATE = 8'h10;
   localparam logic [7:0]  IDX_IRQ_EN    = 8'h12;
   localparam logic [7:0]  IDX_IRQ_STAT  = 8'h13;
   localparam int unsigned BIT_CP        = 7;
   localparam int unsigned BIT_LOS       = 6;
   localparam int unsigned BIT_AIS       = 5;
   localparam int unsigned BIT_IDLE      = 4;
   localparam int unsigned BIT_FERF      = 3;
   localparam int unsigned BIT_AIC       = 2;
   localparam int unsigned BIT_OOF       = 1;
   localparam int unsigned BIT_PERR      = 0;
   localparam int unsigned CFG_AIS       = 7;
   localparam int unsigned CFG_LOS       = 6;
   localparam int unsigned CFG_IDLE      = 5;
   localparam int unsigned CFG_OOF       = 4;
   localparam int unsigned CFG_RSVD      = 3;
   localparam logic [7:0]  RST_IRQ_EN    = 8'h00;
   localparam logic [7:0]  RST_IRQ_STAT  = 8'h00;
   localparam logic [2:0]  RST_CFG_SEL   = 3'h0;
   localparam int unsigned AIS_FRAMES    = 63;
   localparam int unsigned FBIT_WINDOW   = 16;
   localparam int unsigned OOF_THR_LOW   = 3;
   localparam int unsigned OOF_THR_HIGH  = 6;

   typedef struct packed {
      logic parity_framing;
      logic f_bit_sync_select;
      logic m_bit_sync_select;
   } dra_cfg_t;

   typedef struct packed {
      logic fbit_valid;
      logic fbit_err;
      logic frame_end;
      logic frame_ais;
      logic inframe_entry;
      logic signal_loss_state;
      logic idle_pattern_state;
      logic cp_err;
      logic ferf_change;
      logic aic_change;
      logic p_err;
   } dra_rx_t;

   typedef enum logic [1:0] {
      AIS_CLEAR = 2'b01,
      AIS_SET   = 2'b10
   } dra_ais_st_t;
endpackage

// ---- verilog/dra_oof_detect.sv ----
// out-of-frame declaration over a sliding window of f-bits
`timescale 1ns/1ps
module dra_oof_detect #(
   parameter int unsigned WINDOW   = dra_pkg::FBIT_WINDOW,
   parameter int unsigned THR_LOW  = dra_pkg::OOF_THR_LOW,
   parameter int unsigned THR_HIGH = dra_pkg::OOF_THR_HIGH
) (
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   input  wire logic i_fbit_valid,
   input  wire logic i_fbit_err,
   input  wire logic i_thr_high,
   input  wire logic i_inframe_entry,
   output logic      o_frame_loss_state
);
   if (WINDOW < 2 || WINDOW > 255 || THR_LOW == 0 || THR_HIGH > WINDOW || THR_LOW > WINDOW)
   begin : g_bad
      $error("dra_oof_detect: unsupported window or threshold");
   end

   logic [WINDOW-1:0] hist_q;
   logic              oof_q;
   logic [7:0]        thr;

   function automatic logic [7:0] ones(input logic [WINDOW-1:0] v);
      logic [7:0] n;
      n = 8'h00;
      for (int i = 0; i < WINDOW; i++)
      begin
         n = n + {7'h00, v[i]};
      end
      return n;
   endfunction

   assign thr = i_thr_high ? 8'(THR_HIGH) : 8'(THR_LOW);

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n || i_inframe_entry)
         hist_q <= '0;
      else if (i_fbit_valid)
         hist_q <= {hist_q[WINDOW-2:0], i_fbit_err};
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         oof_q <= 1'b0;
      else if (i_inframe_entry)
         oof_q <= 1'b0;
      else if (ones(hist_q) >= thr)
         oof_q <= 1'b1;
   end

   assign o_frame_loss_state = oof_q;
endmodule // dra_oof_detect

// ---- verilog/dra_ais_detect.sv ----
// ais declaration and clearing by consecutive frame counting
`timescale 1ns/1ps
module dra_ais_detect #(
   parameter int unsigned FRAMES = dra_pkg::AIS_FRAMES
) (
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   input  wire logic i_frame_end,
   input  wire logic i_frame_ais,
   output logic      o_alarm_signal_state
);
   if (FRAMES < 1 || FRAMES > 4096)
   begin : g_bad
      $error("dra_ais_detect: unsupported frame count");
   end

   localparam int unsigned CW = $clog2(FRAMES + 1);

   dra_pkg::dra_ais_st_t st_q;
   logic [CW-1:0]        cnt_q;
   logic                 match;
   logic                 last;

   assign match = (st_q == dra_pkg::AIS_CLEAR) ? i_frame_ais : !i_frame_ais;
   assign last  = (cnt_q == CW'(FRAMES - 1));

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         cnt_q <= '0;
      else if (i_frame_end)
         cnt_q <= (match && !last) ? cnt_q + CW'(1) : '0;
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         st_q <= dra_pkg::AIS_CLEAR;
      else if (i_frame_end && match && last)
      begin
         unique case (st_q)
            dra_pkg::AIS_CLEAR: st_q <= dra_pkg::AIS_SET;
            dra_pkg::AIS_SET:   st_q <= dra_pkg::AIS_CLEAR;
            default:            st_q <= dra_pkg::AIS_CLEAR;
         endcase
      end
   end

   assign o_alarm_signal_state = (st_q == dra_pkg::AIS_SET);
endmodule // dra_ais_detect

// ---- verification/dra_host_model.sv ----
// apb host model that services the receive alarm interrupts
`timescale 1ns/1ps
module dra_host_model (
   input  wire logic        i_clk,
   input  wire logic [31:0] i_prdata,
   input  wire logic        i_pready,
   input  wire logic        i_pslverr,
   output logic             o_psel,
   output logic             o_penable,
   output logic             o_pwrite,
   output logic [7:0]       o_paddr,
   output logic [31:0]      o_pwdata
);
   localparam logic [7:0] A_CFG  = dra_pkg::IDX_CFG_STATE << 2;
   localparam logic [7:0] A_STAT = dra_pkg::IDX_IRQ_STAT << 2;
   int feac_set;
   int feac_clr;

   initial
   begin
      o_psel    = 1'b0;
      o_penable = 1'b0;
      o_pwrite  = 1'b0;
      o_paddr   = 8'h00;
      o_pwdata  = 32'h0;
      feac_set  = 0;
      feac_clr  = 0;
   end

   // one apb transfer, held until pready is sampled high
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
      @(posedge i_clk);
      o_psel    <= 1'b1;
      o_penable <= 1'b0;
      o_pwrite  <= wr;
      o_paddr   <= a;
      o_pwdata  <= wd;
      @(posedge i_clk);
      o_penable <= 1'b1;
      do
      begin
         @(posedge i_clk);
      end
      while (i_pready !== 1'b1);
      rd = i_prdata;
      err = i_pslverr;
      o_psel    <= 1'b0;
      o_penable <= 1'b0;
   endtask

   // read status then live state, report to the remote end
   task automatic service(output logic [7:0] st, output logic [7:0] cf);
      logic [31:0] d;
      logic        e;
      xfer(1'b0, A_STAT, 32'h0, d, e);
      st = d[7:0];
      xfer(1'b0, A_CFG, 32'h0, d, e);
      cf = d[7:0];
      if ((st[5] | st[1]) && (cf[7] | cf[4])) feac_set++;
      if ((st[5] | st[1]) && !(cf[7] | cf[4])) feac_clr++;
   endtask
endmodule // dra_host_model

// ---- verification/test_ds3_rx_alarm_interrupts.sv ----
// self-checking bench for the receive alarm interrupt block
`timescale 1ns/1ps
module test_ds3_rx_alarm_interrupts;
   localparam int unsigned AISF   = 4;
   localparam logic [7:0]  A_CFG  = dra_pkg::IDX_CFG_STATE << 2;
   localparam logic [7:0]  A_EN   = dra_pkg::IDX_IRQ_EN << 2;
   localparam logic [7:0]  A_STAT = dra_pkg::IDX_IRQ_STAT << 2;
   logic              i_clk;
   logic              i_rst_n;
   logic              psel, penable, pwrite, pready, pslverr;
   logic [7:0]        paddr;
   logic [31:0]       pwdata, prdata, d;
   logic              e;
   dra_pkg::dra_rx_t  rx, base, v;
   dra_pkg::dra_cfg_t o_cfg;
   logic              o_frame_loss_state, o_alarm_signal_state, o_ferf_send, o_irq_n;
   logic [7:0]        exp_en, exp_stat, v8;
   logic [2:0]        m_cfg;
   logic              m_ais, m_oof;
   logic              fq[$];
   int                errors, checks, a_cnt, ne, m_set, m_clr, seed_v;

   dra_host_model host_u (.i_clk(i_clk), .i_prdata(prdata), .i_pready(pready),
      .i_pslverr(pslverr), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
      .o_paddr(paddr), .o_pwdata(pwdata));

   dra_rx_alarm_irq #(.AIS_FRAMES(AISF), .FBIT_WINDOW(dra_pkg::FBIT_WINDOW)) dut_u (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_rx(rx), .o_cfg(o_cfg),
      .o_frame_loss_state(o_frame_loss_state), .o_alarm_signal_state(o_alarm_signal_state),
      .o_ferf_send(o_ferf_send), .o_irq_n(o_irq_n));

   initial
   begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
      checks++;
      if (s !== x)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", n, x, s);
      end
   endtask

   task automatic results;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] x);
      host_u.xfer(1'b1, a, {24'h0, x}, d, e);
   endtask

   task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] x);
      host_u.xfer(1'b0, a, 32'h0, d, e);
      chk(n, d, x);
      chk("pslverr", e, 1'b0);
   endtask

   task automatic pulse(input dra_pkg::dra_rx_t p);
      @(posedge i_clk);
      rx <= p;
      @(posedge i_clk);
      rx <= base;
   endtask

   task automatic cmp_out;
      repeat (3) @(posedge i_clk);
      #1;
      chk("ais_state", o_alarm_signal_state, m_ais);
      chk("oof_state", o_frame_loss_state, m_oof);
      chk("ferf_send", o_ferf_send, m_ais | m_oof);
      chk("irq_n", o_irq_n, ~|(exp_stat & exp_en));
   endtask

   task automatic serve;
      logic [7:0] st, cf;
      host_u.service(st, cf);
      chk("status", st, exp_stat);
      chk("cfg_state", cf, {m_ais, base.signal_loss_state, base.idle_pattern_state,
          m_oof, 1'b0, m_cfg});
      if (exp_stat[5] | exp_stat[1]) m_set += (m_ais | m_oof);
      if (exp_stat[5] | exp_stat[1]) m_clr += !(m_ais | m_oof);
      exp_stat = 8'h00;
      cmp_out();
   endtask

   task automatic frames(input int n, input logic ais);
      repeat (n)
      begin
         v = base;
         v.frame_end = 1'b1;
         v.frame_ais = ais;
         pulse(v);
         a_cnt = (ais != m_ais) ? a_cnt + 1 : 0;
         if (a_cnt == AISF)
         begin
            m_ais = ais;
            a_cnt = 0;
            exp_stat[5] = exp_stat[5] | exp_en[5];
         end
      end
   endtask

   task automatic fbits(input int n, input logic err);
      repeat (n)
      begin
         v = base;
         v.fbit_valid = 1'b1;
         v.fbit_err = err;
         pulse(v);
         fq.push_back(err);
         if (fq.size() > dra_pkg::FBIT_WINDOW) void'(fq.pop_front());
         ne = 0;
         foreach (fq[k]) ne += fq[k];
         if (!m_oof && ne >= (m_cfg[1] ? 6 : 3))
         begin
            m_oof = 1'b1;
            exp_stat[1] = exp_stat[1] | exp_en[1];
         end
      end
   endtask

   task automatic inframe;
      fbits(dra_pkg::FBIT_WINDOW, 1'b0);
      v = base;
      v.inframe_entry = 1'b1;
      pulse(v);
      fq.delete();
      m_oof = 1'b0;
      exp_stat[1] = exp_stat[1] | exp_en[1];
      cmp_out();
      serve();
   endtask

   initial
   begin
      repeat (20000) @(posedge i_clk);
      errors++;
      results();
   end

   initial
   begin
      {errors, checks, a_cnt, m_set, m_clr} = '0;
      {rx, base, exp_en, exp_stat, m_cfg, m_ais, m_oof} = '0;
      i_rst_n = 1'b0;
      seed_v = $urandom(3);
      repeat (8) @(posedge i_clk);
      i_rst_n <= 1'b1;
      rd_chk("cfg_reset", A_CFG, 32'h0);
      rd_chk("en_reset", A_EN, 32'h0);
      rd_chk("stat_reset", A_STAT, 32'h0);
      host_u.xfer(1'b0, 8'h44, 32'h0, d, e);
      chk("unmapped_err", e, 1'b1);
      chk("unmapped_data", d, 32'h0);
      wr(A_CFG, 8'hff);
      m_cfg = 3'h7;
      rd_chk("cfg_rw", A_CFG, 32'h07);
      chk("o_cfg", o_cfg, m_cfg);
      wr(A_CFG, 8'h00);
      m_cfg = 3'h0;
      repeat (4)
      begin
         v8 = 8'($urandom);
         wr(A_EN, v8);
         rd_chk("en_rw", A_EN, {24'h0, v8});
      end
      wr(A_EN, 8'h00);
      frames(AISF, 1'b1);
      cmp_out();
      serve();
      exp_en = 8'h22;
      wr(A_EN, exp_en);
      frames(AISF, 1'b0);
      cmp_out();
      serve();
      frames(AISF - 1, 1'b1);
      frames(1, 1'b0);
      frames(AISF - 1, 1'b1);
      cmp_out();
      frames(1, 1'b1);
      cmp_out();
      serve();
      fbits(2, 1'b1);
      fbits(3, 1'b0);
      cmp_out();
      fbits(1, 1'b1);
      cmp_out();
      serve();
      inframe();
      wr(A_CFG, 8'h02);
      m_cfg = 3'h2;
      fbits(5, 1'b1);
      cmp_out();
      fbits(1, 1'b1);
      cmp_out();
      serve();
      inframe();
      exp_en = 8'hff;
      wr(A_EN, exp_en);
      for (int i = 0; i < 6; i++)
      begin
         v = base;
         case (i)
            0: v.cp_err = 1'b1;
            1: v.ferf_change = 1'b1;
            2: v.aic_change = 1'b1;
            3: v.p_err = 1'b1;
            4: base.signal_loss_state = 1'b1;
            default: base.idle_pattern_state = 1'b1;
         endcase
         pulse((i < 4) ? v : base);
      end
      exp_stat = 8'hdd;
      cmp_out();
      serve();
      v = base;
      v.cp_err = 1'b1;
      @(posedge i_clk);
      rx <= v;
      rd_chk("stat_in_read", A_STAT, 32'h80);
      rx <= base;
      rd_chk("stat_kept", A_STAT, 32'h80);
      rd_chk("stat_cleared", A_STAT, 32'h0);
      cmp_out();
      chk("feac_set", host_u.feac_set, m_set);
      chk("feac_clr", host_u.feac_clr, m_clr);
      results();
   end
endmodule // test_ds3_rx_alarm_interrupts
